// file: design/pwm_cfg_consts.vh
// Constants for the power stage unit configuration and run control.
// Assumes a 32-bit APB slave with word-aligned registers.
`ifndef PWM_CFG_CONSTS_VH
`define PWM_CFG_CONSTS_VH
// Word slots inside one unit's 32-byte window (paddr[4:2])
`define REG_CNF      3'h0
`define REG_CTL      3'h1
`define REG_SA       3'h2
`define REG_RA       3'h3
`define REG_SB       3'h4
`define REG_RB       3'h5
`define REG_SOC      3'h6
`define REG_STAT     3'h7
// Unit window index of the output matrix (byte address 0x60)
`define UNIT_MATRIX  3'h3
// Configuration register fields
`define CNF_FIFTY    7
`define CNF_ALOCK    6
`define CNF_LOCK     5
`define CNF_MODE     4:3
`define CNF_POL      2
`define CNF_CLKSEL   1
`define CNF_MATRIX   0
// Control register fields
`define CTL_PRESC    7:6
`define CTL_BFM      5
`define CTL_AOCB     4
`define CTL_AOCA     3
`define CTL_ARUN     2
`define CTL_CCYC     1
`define CTL_RUN      0
// Output configuration enables
`define SOC_OE_A     0
`define SOC_OE_B     2
// Ramp modes
`define MODE_ONE     2'h0
`define MODE_TWO     2'h1
`define MODE_FOUR    2'h2
`define MODE_CENTRE  2'h3
// Prescaler masks: no division, by 4, by 16, by 64
`define PRE_M1       6'h00
`define PRE_M4       6'h03
`define PRE_M16      6'h0F
`define PRE_M64      6'h3F
// Reset value of every register
`define REG_RESET    8'h00
`endif

// file: design/power_stage_pwm_config_ctrl.v
// Configuration and run control for three 12-bit power stage units.
// Assumes an APB3 master on clk_in, fast and slow unit clocks and fault
// inputs arriving as asynchronous pins.
// Notes on behaviour
// - Fifty mode copies B compares into A
// - Autolock transfers only after compare RB written last
// - Autolock wins over plain lock
// - Lock holds all buffered writes until released
// - Mode field selects one, two, four, centre
// - Polarity bit: clear active low, set high
// - Clock select: set fast, clear slow
// - Matrix enable exists on third unit only
// - Matrix enabled ignores output polarity
// - Prescaler divides by 1, 4, 16, 64
// - Balance bit extends flank modulation to A
// - Async control lets raw fault force outputs
// - First unit autorun follows third unit
// - Complete-cycle finishes cycle before halting
// - Complete-cycle ignored while autorun set
// - Writing run one starts unit immediately
// - Run bit prevails over autorun
// - All registers reset to zero
// - Second unit autorun follows first unit
// - Third unit autorun follows second unit
//
// Our own choices: the placing of the registers and the APB register port.
`timescale 1ns/1ps
`include "pwm_cfg_consts.vh"
module power_stage_pwm_config_ctrl #(
  parameter ADDR_W = 12
) (
  input  wire              clk_in,
  input  wire              reset_in,
  input  wire              psel_in,
  input  wire              penable_in,
  input  wire              pwrite_in,
  input  wire [ADDR_W-1:0] paddr_in,
  input  wire [31:0]       pwdata_in,
  output reg  [31:0]       prdata_out,
  output reg               pready_out,
  output reg               pslverr_out,
  input  wire              fast_clock_in,
  input  wire              slow_clock_in,
  input  wire [2:0]        fault_a_in,
  input  wire [2:0]        fault_b_in,
  output wire [2:0]        wave_out_a_out,
  output wire [2:0]        wave_out_b_out,
  output reg  [2:0]        wave_oe_a_out,
  output reg  [2:0]        wave_oe_b_out,
  output reg  [2:0]        running_out
);

  // Pin synchronisers: {fault_b, fault_a, slow, fast}
  reg  [7:0]  sync1_q;
  reg  [7:0]  sync2_q;
  reg  [7:0]  sync3_q;
  reg  [7:0]  settled_q;
  wire [7:0]  agree;
  wire [1:0]  clk_rise;
  wire [2:0]  flt_a;
  wire [2:0]  flt_b;

  assign agree    = ~(sync2_q ^ sync3_q);
  assign clk_rise = agree[1:0] & sync3_q[1:0] & ~settled_q[1:0];
  assign flt_a    = settled_q[4:2];
  assign flt_b    = settled_q[7:5];

  // Three flops; a change counts once stages two and three agree
  always @(posedge clk_in) begin
    if (reset_in) begin
      sync1_q   <= 8'h00;
      sync2_q   <= 8'h00;
      sync3_q   <= 8'h00;
      settled_q <= 8'h00;
    end else begin
      sync1_q   <= {fault_b_in, fault_a_in, slow_clock_in, fast_clock_in};
      sync2_q   <= sync1_q;
      sync3_q   <= sync2_q;
      settled_q <= (settled_q & ~agree) | (sync3_q & agree);
    end
  end

  // APB decode; one wait state, so pready rises in the second access cycle
  wire [2:0]  uidx;
  wire [2:0]  ridx;
  wire        hi_zero;
  wire        map_ok;
  wire        wr;
  reg         pready_q;

  assign uidx    = paddr_in[7:5];
  assign ridx    = paddr_in[4:2];
  assign hi_zero = (paddr_in[ADDR_W-1:8] == {(ADDR_W-8){1'b0}}) &&
                   (paddr_in[1:0] == 2'h0);
  assign map_ok  = hi_zero && ((uidx < 3'h3) ||
                   (uidx == `UNIT_MATRIX && ridx == 3'h0));
  assign wr      = psel_in & penable_in & pready_q & pwrite_in & map_ok;

  // Output matrix lives once, beside the third unit
  reg  [7:0]  mat_s_q;
  reg  [7:0]  mat_w_q;
  wire        wr_mat;
  wire [2:0]  xfer_v;
  wire [2:0]  run_v;
  wire [2:0]  arun_v;
  wire [95:0] rd_v;
  wire [2:0]  wa_v;
  wire [2:0]  wb_v;
  wire [2:0]  inact_v;
  wire [2:0]  aoca_v;
  wire [2:0]  aocb_v;

  assign wr_mat = wr && uidx == `UNIT_MATRIX;

  // Matrix shadow and working copy; update strobe comes from unit two
  always @(posedge clk_in) begin
    if (reset_in) begin
      mat_s_q <= `REG_RESET;
      mat_w_q <= `REG_RESET;
    end else begin
      if (wr_mat)
        mat_s_q <= pwdata_in[7:0];
      if (xfer_v[2])
        mat_w_q <= mat_s_q;
    end
  end

  genvar i;
  generate
    for (i = 0; i < 3; i = i + 1) begin : unit
      reg  [7:0]  cnf_q;
      reg  [7:0]  ctl_q;
      reg  [7:0]  soc_s_q;
      reg  [7:0]  soc_w_q;
      reg  [11:0] sa_s_q;
      reg  [11:0] ra_s_q;
      reg  [11:0] sb_s_q;
      reg  [15:0] rb_s_q;
      reg  [11:0] sa_w_q;
      reg  [11:0] ra_w_q;
      reg  [11:0] sb_w_q;
      reg  [15:0] rb_w_q;
      reg         rb_last_q;
      reg         run_q;
      reg         dir_q;
      reg         ext_q;
      reg  [3:0]  acc_q;
      reg  [1:0]  ramp_q;
      reg  [11:0] cnt_q;
      reg  [5:0]  pre_q;
      reg         wa_q;
      reg         wb_q;
      reg  [31:0] rd;
      reg  [5:0]  pmask;
      wire        wsel;
      wire        mat_en;
      wire        centre;
      wire        src_tick;
      wire        tick;
      wire        ramp_last;
      wire        at_top;
      wire        cyc_end;
      wire        start_req;
      wire        upd;
      wire        a_ok;
      wire        b_ok;
      wire        a_act;
      wire        b_act;
      wire [12:0] ra_end;
      wire [12:0] rb_end;
      wire [4:0]  acc_sum;
      wire [1:0]  mode;
      wire        pol;

      assign wsel   = wr && uidx == i;
      assign mat_en = (i == 2) && cnf_q[`CNF_MATRIX];
      assign mode   = cnf_q[`CNF_MODE];
      assign pol    = cnf_q[`CNF_POL];
      assign centre = mode == `MODE_CENTRE;

      // Clock source and prescaler; slower rates are enables, not clocks
      assign src_tick = cnf_q[`CNF_CLKSEL] ? clk_rise[0]
                                           : clk_rise[1];
      always @* begin
        case (ctl_q[`CTL_PRESC])
          2'h0:    pmask = `PRE_M1;
          2'h1:    pmask = `PRE_M4;
          2'h2:    pmask = `PRE_M16;
          default: pmask = `PRE_M64;
        endcase
      end
      assign tick = run_q & src_tick & ((pre_q & pmask) == pmask);

      // Cycle framing per ramp mode
      assign at_top    = cnt_q == rb_w_q[11:0];
      assign ramp_last = (mode == `MODE_TWO)  ? (ramp_q == 2'h1) :
                         (mode == `MODE_FOUR) ? (ramp_q == 2'h3) :
                         1'b1;
      assign cyc_end   = tick & (centre ? (dir_q && cnt_q == 12'h000)
                                        : (at_top & ramp_last));

      // Chained start: partner before, and its own partner before
      assign start_req = run_v[i] | (arun_v[i] &
                         (run_v[(i+2)%3] | (arun_v[(i+2)%3] &
                          run_v[(i+1)%3])));

      // Autolock first, then lock, else update at cycle end or while stopped
      assign upd = ~run_q | cyc_end;
      assign xfer_v[i] = cnf_q[`CNF_ALOCK] ? (rb_last_q & upd)
                       : (~cnf_q[`CNF_LOCK] & upd);

      // Flank modulation stretches B, and A too when balanced
      assign acc_sum = {1'b0, acc_q} + {1'b0, rb_w_q[15:12]};
      assign rb_end  = {1'b0, rb_w_q[11:0]} + {12'h000, ext_q};
      assign ra_end  = {1'b0, ra_w_q} +
                       {12'h000, ext_q & ctl_q[`CTL_BFM]};
      assign a_ok  = (mode == `MODE_ONE) | centre | ~ramp_q[0];
      assign b_ok  = (mode == `MODE_ONE) | centre | ramp_q[0];
      assign a_act = a_ok && cnt_q >= sa_w_q &&
                     {1'b0, cnt_q} < ra_end;
      assign b_act = b_ok && cnt_q >= sb_w_q &&
                     {1'b0, cnt_q} <= rb_end;

      // Register writes; shadows feed working copies on transfer
      always @(posedge clk_in) begin
        if (reset_in) begin
          cnf_q     <= `REG_RESET;
          ctl_q     <= `REG_RESET;
          soc_s_q   <= `REG_RESET;
          soc_w_q   <= `REG_RESET;
          sa_s_q    <= 12'h000;
          ra_s_q    <= 12'h000;
          sb_s_q    <= 12'h000;
          rb_s_q    <= 16'h0000;
          sa_w_q    <= 12'h000;
          ra_w_q    <= 12'h000;
          sb_w_q    <= 12'h000;
          rb_w_q    <= 16'h0000;
          rb_last_q <= 1'b0;
        end else begin
          if (wsel) begin
            case (ridx)
              `REG_CNF: cnf_q <= pwdata_in[7:0] &
                                 {7'h7F, (i == 2)};
              `REG_CTL: ctl_q  <= pwdata_in[7:0];
              `REG_SA:  sa_s_q <= pwdata_in[11:0];
              `REG_RA:  ra_s_q <= pwdata_in[11:0];
              `REG_SB:  sb_s_q <= pwdata_in[11:0];
              `REG_RB: begin
                rb_s_q <= pwdata_in[15:0];
                if (cnf_q[`CNF_FIFTY]) begin
                  sa_s_q <= sb_s_q;
                  ra_s_q <= pwdata_in[11:0];
                end
              end
              `REG_SOC: soc_s_q <= pwdata_in[7:0];
              default: ;
            endcase
          end
          if (xfer_v[i]) begin
            sa_w_q  <= sa_s_q;
            ra_w_q  <= ra_s_q;
            sb_w_q  <= sb_s_q;
            rb_w_q  <= rb_s_q;
            soc_w_q <= soc_s_q;
          end
          // Write of RB wins over a same-cycle consume or clear
          if (wsel && ridx == `REG_RB)
            rb_last_q <= 1'b1;
          else if ((wsel && (ridx == `REG_SA || ridx == `REG_RA ||
                    ridx == `REG_SB || ridx == `REG_SOC)) ||
                   (wr_mat && i == 2) ||
                   (xfer_v[i] && cnf_q[`CNF_ALOCK]))
            rb_last_q <= 1'b0;
        end
      end

      // Run state, counter and output levels
      always @(posedge clk_in) begin
        if (reset_in) begin
          run_q  <= 1'b0;
          dir_q  <= 1'b0;
          ext_q  <= 1'b0;
          acc_q  <= 4'h0;
          ramp_q <= 2'h0;
          cnt_q  <= 12'h000;
          pre_q  <= 6'h00;
          wa_q   <= 1'b1;
          wb_q   <= 1'b1;
        end else begin
          if (start_req)
            run_q <= 1'b1;
          else if (run_q && (!ctl_q[`CTL_CCYC] || arun_v[i] || cyc_end))
            run_q <= 1'b0;
          if (!run_q) begin
            pre_q  <= 6'h00;
            cnt_q  <= 12'h000;
            ramp_q <= 2'h0;
            dir_q  <= 1'b0;
          end else begin
            if (src_tick)
              pre_q <= pre_q + 6'h01;
            if (tick) begin
              if (centre) begin
                if (!dir_q && at_top)
                  dir_q <= 1'b1;
                else if (dir_q && cnt_q == 12'h000)
                  dir_q <= 1'b0;
                else if (dir_q)
                  cnt_q <= cnt_q - 12'h001;
                else
                  cnt_q <= cnt_q + 12'h001;
              end else if (at_top) begin
                cnt_q  <= 12'h000;
                ramp_q <= ramp_last ? 2'h0 : ramp_q + 2'h1;
              end else begin
                cnt_q <= cnt_q + 12'h001;
              end
            end
          end
          if (cyc_end) begin
            acc_q <= acc_sum[3:0];
            ext_q <= acc_sum[4];
          end
          // Matrix picks levels per ramp and bypasses polarity
          if (!run_q || flt_a[i])
            wa_q <= inact_v[i];
          else if (mat_en)
            wa_q <= mat_w_q[{ramp_q, 1'b0}];
          else
            wa_q <= ~(a_act ^ pol);
          if (!run_q || flt_b[i])
            wb_q <= inact_v[i];
          else if (mat_en)
            wb_q <= mat_w_q[{ramp_q, 1'b1}];
          else
            wb_q <= ~(b_act ^ pol);
        end
      end

      assign run_v[i]   = ctl_q[`CTL_RUN];
      assign arun_v[i]  = ctl_q[`CTL_ARUN];
      assign aoca_v[i]  = ctl_q[`CTL_AOCA];
      assign aocb_v[i]  = ctl_q[`CTL_AOCB];
      assign inact_v[i] = mat_en ? 1'b0 : ~pol;
      assign wa_v[i]    = wa_q;
      assign wb_v[i]    = wb_q;

      // Readback, including live state in the status slot
      always @* begin
        rd = 32'h0000_0000;
        case (ridx)
          `REG_CNF:  rd[7:0]  = cnf_q;
          `REG_CTL:  rd[7:0]  = ctl_q;
          `REG_SA:   rd[11:0] = sa_s_q;
          `REG_RA:   rd[11:0] = ra_s_q;
          `REG_SB:   rd[11:0] = sb_s_q;
          `REG_RB:   rd[15:0] = rb_s_q;
          `REG_SOC:  rd[7:0]  = soc_s_q;
          default:   rd = {4'h0, cnt_q, 11'h000, ramp_q,
                           dir_q, rb_last_q, run_q};
        endcase
      end
      assign rd_v[i*32 +: 32] = rd;
    end
  endgenerate

  // Raw fault bypasses the flop when async control is set; this path
  // has no clock on purpose, so glitches on the pin reach the output
  assign wave_out_a_out = (aoca_v & fault_a_in & inact_v) |
                          (~(aoca_v & fault_a_in) & wa_v);
  assign wave_out_b_out = (aocb_v & fault_b_in & inact_v) |
                          (~(aocb_v & fault_b_in) & wb_v);

  // APB answer and registered unit status outputs
  always @(posedge clk_in) begin
    if (reset_in) begin
      pready_q      <= 1'b0;
      pready_out    <= 1'b0;
      pslverr_out   <= 1'b0;
      prdata_out    <= 32'h0000_0000;
      wave_oe_a_out <= 3'h0;
      wave_oe_b_out <= 3'h0;
      running_out   <= 3'h0;
    end else begin
      pready_q    <= psel_in & penable_in & ~pready_q;
      pready_out  <= psel_in & penable_in & ~pready_q;
      pslverr_out <= psel_in & penable_in & ~pready_q & ~map_ok;
      if (psel_in && penable_in && !pready_q && !pwrite_in && map_ok) begin
        if (uidx == `UNIT_MATRIX)
          prdata_out <= {24'h000000, mat_s_q};
        else
          prdata_out <= rd_v[uidx[1:0]*32 +: 32];
      end else begin
        prdata_out <= 32'h0000_0000;
      end
      wave_oe_a_out <= {unit[2].soc_w_q[`SOC_OE_A],
                        unit[1].soc_w_q[`SOC_OE_A],
                        unit[0].soc_w_q[`SOC_OE_A]};
      wave_oe_b_out <= {unit[2].soc_w_q[`SOC_OE_B],
                        unit[1].soc_w_q[`SOC_OE_B],
                        unit[0].soc_w_q[`SOC_OE_B]};
      running_out   <= {unit[2].run_q, unit[1].run_q, unit[0].run_q};
    end
  end

endmodule // power_stage_pwm_config_ctrl

// file: testbench/power_switch_model.sv
// Switch model for unit 0 output A: counts turn-on events.
// Assumes a switch conducts while its pin is driven high.
`timescale 1ns/1ps
module power_switch_model (
  input  wire logic        clk_in,
  input  wire logic        clr_in,
  input  wire logic        gate_in,
  input  wire logic        drive_en_in,
  output logic      [15:0] on_count_out
);
  logic on_q;
  // Undriven pin leaves the switch open
  always @(posedge clk_in) begin
    on_q <= gate_in & drive_en_in;
    if (clr_in)
      on_count_out <= 16'h0000;
    else if (gate_in & drive_en_in & !on_q)
      on_count_out <= on_count_out + 16'h0001;
  end
endmodule // power_switch_model

// file: testbench/pwm_cfg_assertions.sv
// Checker for bus handshake, run control and fault paths.
// Assumes a bind to the top module; sees its ports only.
`timescale 1ns/1ps
module pwm_cfg_checker #(
  parameter ADDR_W = 12
) (
  input wire logic              clk_in,
  input wire logic              reset_in,
  input wire logic              psel_in,
  input wire logic              penable_in,
  input wire logic              pwrite_in,
  input wire logic [ADDR_W-1:0] paddr_in,
  input wire logic [31:0]       pwdata_in,
  input wire logic [31:0]       prdata_out,
  input wire logic              pready_out,
  input wire logic              pslverr_out,
  input wire logic [2:0]        fault_a_in,
  input wire logic [2:0]        fault_b_in,
  input wire logic [2:0]        wave_out_a_out,
  input wire logic [2:0]        wave_out_b_out,
  input wire logic [2:0]        wave_oe_a_out,
  input wire logic [2:0]        running_out
);
  logic [7:0] cnf0_q;
  logic [7:0] ctl0_q;
  wire        wr_c = psel_in & penable_in & pwrite_in & pready_out;
  default clocking @(posedge clk_in); endclocking
  default disable iff (reset_in);
  // Copies of unit 0 settings, taken at the commit edge
  always @(posedge clk_in) begin
    if (reset_in) begin
      cnf0_q <= 8'h00;
      ctl0_q <= 8'h00;
    end else if (wr_c && paddr_in == ADDR_W'('h0))
      cnf0_q <= pwdata_in[7:0];
    else if (wr_c && paddr_in == ADDR_W'('h4))
      ctl0_q <= pwdata_in[7:0];
  end
  sequence s_ctl0_wr;
    wr_c && paddr_in == ADDR_W'('h4);
  endsequence
  property p_rdy_pulse;
    pready_out |=> !pready_out;
  endproperty
  property p_rdy_cause;
    pready_out |-> $past(psel_in && penable_in);
  endproperty
  property p_err_cause;
    pslverr_out |-> pready_out;
  endproperty
  property p_rdata_idle;
    !pready_out |-> prdata_out == 32'h0;
  endproperty
  property p_reset_vals;
    $fell(reset_in) |-> running_out == 3'h0 && wave_oe_a_out == 3'h0;
  endproperty
  property p_run_start;
    s_ctl0_wr ##0 pwdata_in[0] |-> ##[1:3] running_out[0];
  endproperty
  property p_stop;
    s_ctl0_wr ##0 pwdata_in[2:0] == 3'h0 |-> ##[1:3] !running_out[0];
  endproperty
  property p_async_a;
    ctl0_q[3] && fault_a_in[0] |-> wave_out_a_out[0] == !cnf0_q[2];
  endproperty
  property p_async_b;
    ctl0_q[4] && fault_b_in[0] |-> wave_out_b_out[0] == !cnf0_q[2];
  endproperty
  a_rdy_pulse: assert property (p_rdy_pulse)
    else $error("ready longer than one cycle");
  a_rdy_cause: assert property (p_rdy_cause)
    else $error("ready without access phase");
  a_err_cause: assert property (p_err_cause)
    else $error("error without ready");
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data outside ready cycle");
  a_reset_vals: assert property (p_reset_vals)
    else $error("unit state not clear after reset");
  a_run_start: assert property (p_run_start)
    else $error("unit 0 did not start");
  a_stop: assert property (p_stop)
    else $error("unit 0 did not halt");
  a_async_a: assert property (p_async_a)
    else $error("fault A did not force output");
  a_async_b: assert property (p_async_b)
    else $error("fault B did not force output");
endmodule // pwm_cfg_checker
bind power_stage_pwm_config_ctrl pwm_cfg_checker #(.ADDR_W(ADDR_W))
  u_pwm_cfg_checker (.clk_in, .reset_in, .psel_in, .penable_in,
  .pwrite_in, .paddr_in, .pwdata_in, .prdata_out, .pready_out,
  .pslverr_out, .fault_a_in, .fault_b_in, .wave_out_a_out,
  .wave_out_b_out, .wave_oe_a_out, .running_out);

// file: testbench/power_stage_pwm_config_ctrl_bench.sv
// Self-checking bench for the unit configuration and run control.
// Assumes the design answers APB with pready; a switch loads unit 0.
`timescale 1ns/1ps
module power_stage_pwm_config_ctrl_bench;
  logic        clk_in, reset_in, psel_in, penable_in, pwrite_in;
  logic [11:0] paddr_in;
  logic [31:0] pwdata_in, prdata_out, rd, w32;
  logic        pready_out, pslverr_out, fast_clock_in, slow_clock_in;
  logic [2:0]  fault_a_in, fault_b_in, wave_out_a_out, wave_out_b_out;
  logic [2:0]  wave_oe_a_out, wave_oe_b_out, running_out;
  logic        clr, er;
  logic [15:0] on_cnt;
  logic [7:0]  cv [3];
  integer      seed, fails, check_count, i, u, t, n, e;
  power_stage_pwm_config_ctrl i_power_stage_pwm_config_ctrl (.clk_in,
    .reset_in, .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in,
    .prdata_out, .pready_out, .pslverr_out, .fast_clock_in,
    .slow_clock_in, .fault_a_in, .fault_b_in, .wave_out_a_out,
    .wave_out_b_out, .wave_oe_a_out, .wave_oe_b_out, .running_out);
  power_switch_model i_power_switch_model (.clk_in, .clr_in(clr),
    .gate_in(wave_out_a_out[0]), .drive_en_in(wave_oe_a_out[0]),
    .on_count_out(on_cnt));
  initial begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end
  // Unit clocks: fast every 4 cycles, slow every 20
  always @(posedge clk_in) begin
    t <= (t == 19) ? 0 : t + 1;
    fast_clock_in <= t[1];
    slow_clock_in <= (t >= 10);
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One APB transfer; idle edge first so strobes never toggle twice
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge clk_in);
    psel_in <= 1'b1;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge clk_in);
    penable_in <= 1'b1;
    // No answer time assumed; only the watchdog ends a hung wait
    do begin
      @(posedge clk_in);
    end while (pready_out !== 1'b1);
    rd = prdata_out;
    er = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
  endtask
  task automatic rdchk(input logic [11:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(rd, x);
  endtask
  // Expected running state from run and autorun bits
  function automatic logic [2:0] exp_run(input logic [7:0] c0, c1, c2);
    logic [2:0] r, a;
    r = {c2[0], c1[0], c0[0]};
    a = {c2[2], c1[2], c0[2]};
    for (int k = 0; k < 3; k++)
      exp_run[k] = r[k] | a[k] & (r[(k+2)%3] | a[(k+2)%3] & r[(k+1)%3]);
  endfunction
  // Cycles of four ticks in an 8192-cycle window
  function automatic int exp_cnt(input logic f, input logic [1:0] p);
    exp_cnt = 8192 / ((f ? 4 : 20) * (1 << (2 * p)) * 4);
  endfunction
  task automatic tally_and_finish;
    $display("Checks %0d, mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    repeat (80000) @(posedge clk_in);
    fails++;
    tally_and_finish;
  end
  initial begin
    seed = 32'h27b5;
    {fails, check_count, t} = 0;
    {psel_in, penable_in, pwrite_in, paddr_in, pwdata_in} = 0;
    {fault_a_in, fault_b_in, fast_clock_in, slow_clock_in, clr} = 0;
    reset_in = 1'b1;
    repeat (5) @(posedge clk_in);
    reset_in <= 1'b0;
    for (i = 0; i <= 'h60; i += 4)
      rdchk(12'(i), 32'h0);
    rdchk(12'h064, 32'h0);
    chk(er, 1);
    apb(1'b1, 12'h026, 32'hFF);
    chk(er, 1);
    $display("Done: reset values and refusals");
    // Random config words; matrix bit exists in unit 2 only
    for (i = 0; i < 9; i++) begin
      u = i % 3;
      w32 = $random(seed);
      apb(1'b1, 12'(u * 32), w32);
      rdchk(12'(u * 32), w32[7:0] & (u == 2 ? 8'hFF : 8'hFE));
    end
    // Random run and autorun chains, complete-cycle kept clear
    for (i = 0; i < 12; i++) begin
      for (u = 0; u < 3; u++) begin
        w32 = $random(seed);
        cv[u] = w32[7:0] & 8'hFD;
        apb(1'b1, 12'(u * 32 + 4), {24'h0, cv[u]});
      end
      repeat (4) @(posedge clk_in);
      chk(running_out, exp_run(cv[0], cv[1], cv[2]));
      rdchk(12'h044, cv[2]);
    end
    for (u = 0; u < 3; u++)
      apb(1'b1, 12'(u * 32 + 4), 32'h0);
    $display("Done: run chains");
    apb(1'b1, 12'h000, 32'h80);
    apb(1'b1, 12'h010, 32'h123);
    apb(1'b1, 12'h014, 32'h456);
    rdchk(12'h008, 32'h123);
    rdchk(12'h00C, 32'h456);
    $display("Done: half duty copy");
    // Active high A output, on for two of four counts
    apb(1'b1, 12'h000, 32'h06);
    apb(1'b1, 12'h008, 32'h0);
    apb(1'b1, 12'h00C, 32'h2);
    apb(1'b1, 12'h014, 32'h3);
    apb(1'b1, 12'h018, 32'h1);
    for (i = 0; i < 5; i++) begin
      apb(1'b1, 12'h000, {29'h0, 1'b1, i < 4, 1'b0});
      apb(1'b1, 12'h004, {24'h0, i[1:0], 6'h01});
      clr <= 1'b1;
      @(posedge clk_in);
      clr <= 1'b0;
      repeat (8192) @(posedge clk_in);
      e = exp_cnt(i < 4, i[1:0]);
      chk(on_cnt + 3 > e && on_cnt < e + 3, 1);
    end
    $display("Done: prescaler and clock select");
    apb(1'b1, 12'h000, 32'h06);
    // Stop first so the cycle starts from a known phase
    apb(1'b1, 12'h004, 32'h0);
    apb(1'b1, 12'h004, 32'hC3);
    apb(1'b1, 12'h004, 32'hC2);
    repeat (8) @(posedge clk_in);
    chk(running_out[0], 1);
    n = 0;
    while (running_out[0] !== 1'b0 && n < 1400) begin
      @(posedge clk_in);
      n++;
    end
    chk(running_out[0], 0);
    chk(n > 900, 1);
    apb(1'b1, 12'h004, 32'hC7);
    apb(1'b1, 12'h004, 32'hC6);
    repeat (4) @(posedge clk_in);
    chk(running_out[0], 0);
    $display("Done: complete cycle halt");
    // Both outputs active all cycle, then raw faults hit them
    apb(1'b1, 12'h00C, 32'h4);
    apb(1'b1, 12'h010, 32'h0);
    apb(1'b1, 12'h018, 32'h5);
    apb(1'b1, 12'h004, 32'h19);
    repeat (40) @(posedge clk_in);
    chk({wave_out_a_out[0], wave_out_b_out[0]}, 2'b11);
    chk({wave_oe_a_out[0], wave_oe_b_out[0]}, 2'b11);
    fault_a_in <= 3'h1;
    fault_b_in <= 3'h1;
    #1;
    chk({wave_out_a_out[0], wave_out_b_out[0]}, 2'b00);
    @(posedge clk_in);
    fault_a_in <= 3'h0;
    fault_b_in <= 3'h0;
    apb(1'b1, 12'h004, 32'h0);
    $display("Done: asynchronous fault path");
    // Unit 1 working copy seen through its output enables
    apb(1'b1, 12'h020, 32'h20);
    apb(1'b1, 12'h038, 32'h5);
    repeat (4) @(posedge clk_in);
    chk({wave_oe_a_out[1], wave_oe_b_out[1]}, 2'b00);
    apb(1'b1, 12'h020, 32'h0);
    repeat (4) @(posedge clk_in);
    chk({wave_oe_a_out[1], wave_oe_b_out[1]}, 2'b11);
    apb(1'b1, 12'h020, 32'h60);
    apb(1'b1, 12'h038, 32'h0);
    repeat (4) @(posedge clk_in);
    chk({wave_oe_a_out[1], wave_oe_b_out[1]}, 2'b11);
    apb(1'b1, 12'h034, 32'h3);
    repeat (4) @(posedge clk_in);
    chk({wave_oe_a_out[1], wave_oe_b_out[1]}, 2'b00);
    apb(1'b1, 12'h038, 32'h5);
    repeat (4) @(posedge clk_in);
    chk({wave_oe_a_out[1], wave_oe_b_out[1]}, 2'b00);
    $display("Done: lock and autolock");
    // Matrix levels are the opposite of what polarity would give here
    apb(1'b1, 12'h040, 32'h1);
    apb(1'b1, 12'h060, 32'hAA);
    apb(1'b1, 12'h044, 32'h1);
    repeat (8) @(posedge clk_in);
    chk({wave_out_a_out[2], wave_out_b_out[2]}, 2'b01);
    apb(1'b1, 12'h044, 32'h0);
    $display("Done: output matrix");
    tally_and_finish;
  end
endmodule // power_stage_pwm_config_ctrl_bench
